// ===== core/rpe_pkg.sv
// shared constants and types for the resonant edge-timing block
package rpe_pkg;

	// clock and tick timing
	localparam int CLK_NS   = 5;
	localparam int TICK_NS  = 5;
	localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int TICK_W   = 4;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_FREQ_SET   = 8'h40;
	localparam logic [7:0] IDX_RISE_DLY   = 8'h41;
	localparam logic [7:0] IDX_MAXPER_HI  = 8'h42;
	localparam logic [7:0] IDX_FALL_OFS   = 8'h43;
	localparam logic [7:0] IDX_MAXPER_LO  = 8'h44;
	localparam logic [7:0] IDX_PER_REQ    = 8'h60;
	localparam logic [7:0] IDX_STATUS     = 8'h61;

	// fields and values
	localparam logic [5:0] RES_ENABLE_CODE = 6'h3F;
	localparam int         FREQ_FLD_MSB    = 5;
	localparam int         MAXLO_FLD_LSB   = 4;
	localparam logic [7:0] FALL_SIGN_CODE  = 8'h80;
	localparam logic [11:0] PER_MIN        = 12'h002;

	// values after reset
	localparam logic [7:0]  RST_FREQ_SET  = 8'h00;
	localparam logic [7:0]  RST_RISE_DLY  = 8'h00;
	localparam logic [7:0]  RST_MAXPER_HI = 8'h00;
	localparam logic [7:0]  RST_FALL_OFS  = 8'h00;
	localparam logic [7:0]  RST_MAXPER_LO = 8'h00;
	localparam logic [11:0] RST_PER_REQ   = 12'h000;

	// status bit positions
	localparam int ST_ACTIVE = 0;
	localparam int ST_FIRST  = 1;
	localparam int ST_CLAMP  = 2;

	// cycle phase, gray along idle -> first -> second
	typedef enum logic [1:0]
	{
		RPE_IDLE   = 2'b00,
		RPE_FIRST  = 2'b01,
		RPE_SECOND = 2'b11
	} rpe_phase_t;

	// four switch drives travel together
	typedef struct packed
	{
		logic a;
		logic b;
		logic c;
		logic d;
	} rpe_drive_t;

	// whole state of the main module
	typedef struct packed
	{
		logic [7:0]  freq;
		logic [7:0]  rise;
		logic [7:0]  maxhi;
		logic [7:0]  maxlo;
		logic [7:0]  fall;
		logic [11:0] req;
		logic [11:0] cnt;
		logic [11:0] per;
		rpe_phase_t  phase;
		logic        clamp;
		logic        busy;
		logic [31:0] rdata;
		rpe_drive_t  drv;
	} rpe_state_t;

	// state of the tick divider
	typedef struct packed
	{
		logic [TICK_W-1:0] div;
		logic              tick;
	} rpe_tick_state_t;

endpackage

// ===== core/rpe_tick.sv
// common timing tick divider
`timescale 1ns/1ps

module rpe_tick
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// tick out
	output logic      tick
);

	localparam logic [rpe_pkg::TICK_W-1:0] LAST =
		rpe_pkg::TICK_W'(rpe_pkg::TICK_CYC - 1);

	rpe_pkg::rpe_tick_state_t s_q;
	rpe_pkg::rpe_tick_state_t s_d;

	////////////////////////////////////////////////////////////////////////
	// divide clk down to one pulse per tick period
	always_comb
	begin
		s_d = s_q;
		if (s_q.div >= LAST)
		begin
			s_d.div  = '0;
			s_d.tick = 1'b1;
		end
		else
		begin
			s_d.div  = s_q.div + 1'b1;
			s_d.tick = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;

endmodule // rpe_tick

// ===== core/rpe_top.sv
// resonant mode edge timing with its register slave
`timescale 1ns/1ps

// Behaviour
// - Resonant operation runs only while the frequency field holds all ones.
// - Drive A rises the programmed count of 5 ns ticks after cycle start.
// - The maximum period is the high byte joined with the companion nibble.
// - Each period count is one 5 ns tick; cycles are capped at that maximum but never run below two ticks.
// - Drive A falls at midpoint plus a negative signed offset in ticks; a positive offset leaves the fall at midpoint.
// - Duty stays fixed and only the cycle length is varied.
// - Drives A and B run in the first half only, C and D in the second.
module rpe_top
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// avalon-mm slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// switch drives
	output logic             first_half_drive_a,
	output logic             first_half_drive_b,
	output logic             second_half_drive_c,
	output logic             second_half_drive_d
);

	rpe_pkg::rpe_state_t s_q;
	rpe_pkg::rpe_state_t s_d;
	logic                tick;
	logic                req;
	logic [7:0]          word;
	logic                active;
	logic [11:0]         max_per;
	logic [11:0]         eff_per;
	logic [11:0]         cnt_nx;
	logic [13:0]         fall_pt;

	////////////////////////////////////////////////////////////////////////
	// helper functions

	// cycle length honouring the lower frequency limit
	function automatic logic [11:0] clamp_per(input logic [11:0] r,
		input logic [11:0] m);
		logic [11:0] v;
		v = (r > m) ? m : r;
		if (v < rpe_pkg::PER_MIN)
			v = rpe_pkg::PER_MIN;
		return v;
	endfunction

	// signed offset code widened to 14 bits
	function automatic logic [13:0] sext_ofs(input logic [7:0] c);
		return {{6{c[7]}}, c};
	endfunction

	// register read mux, unmapped reads as zero
	function automatic logic [31:0] rd_mux(input logic [7:0] w,
		input rpe_pkg::rpe_state_t s, input logic act);
		logic [31:0] r;
		r = '0;
		case (w)
			rpe_pkg::IDX_FREQ_SET:  r = {24'h000000, s.freq};
			rpe_pkg::IDX_RISE_DLY:  r = {24'h000000, s.rise};
			rpe_pkg::IDX_MAXPER_HI: r = {24'h000000, s.maxhi};
			rpe_pkg::IDX_FALL_OFS:  r = {24'h000000, s.fall};
			rpe_pkg::IDX_MAXPER_LO: r = {24'h000000, s.maxlo};
			rpe_pkg::IDX_PER_REQ:   r = {20'h00000, s.req};
			rpe_pkg::IDX_STATUS:
			begin
				r[rpe_pkg::ST_ACTIVE] = act;
				r[rpe_pkg::ST_FIRST]  = (s.phase == rpe_pkg::RPE_FIRST);
				r[rpe_pkg::ST_CLAMP]  = s.clamp;
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// common tick source
	rpe_tick u_tick
	(
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// derived values
	assign req  = avs_read | avs_write;
	assign word = avs_address[9:2];
	assign active = (s_q.freq[rpe_pkg::FREQ_FLD_MSB:0]
		== rpe_pkg::RES_ENABLE_CODE);
	// join high byte with upper nibble
	assign max_per = {s_q.maxhi, s_q.maxlo[7:rpe_pkg::MAXLO_FLD_LSB]};
	assign eff_per = clamp_per(s_q.req, max_per);
	assign cnt_nx  = s_q.cnt + 12'h001;
	assign fall_pt = {3'b000, s_q.per[11:1]} + sext_ofs(s_q.fall);

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb
	begin
		s_d = s_q;

		// bus: one wait cycle, then the answer stands for one cycle
		if (req && s_q.busy)
		begin
			s_d.busy  = 1'b0;
			s_d.rdata = rd_mux(word, s_q, active);
		end
		else
		begin
			s_d.busy = 1'b1;
		end

		// writes land at the edge where waitrequest is seen low
		if (avs_write && !s_q.busy && avs_byteenable[0])
		begin
			case (word)
				rpe_pkg::IDX_FREQ_SET:  s_d.freq  = avs_writedata[7:0];
				rpe_pkg::IDX_RISE_DLY:  s_d.rise  = avs_writedata[7:0];
				rpe_pkg::IDX_MAXPER_HI: s_d.maxhi = avs_writedata[7:0];
				rpe_pkg::IDX_FALL_OFS:  s_d.fall  = avs_writedata[7:0];
				rpe_pkg::IDX_MAXPER_LO: s_d.maxlo = avs_writedata[7:0];
				rpe_pkg::IDX_PER_REQ:
				begin
					s_d.req[7:0] = avs_writedata[7:0];
					if (avs_byteenable[1])
						s_d.req[11:8] = avs_writedata[11:8];
				end
				default: s_d.freq = s_q.freq;
			endcase
		end

		// cycle counter; new length only taken at cycle start
		if (!active)
		begin
			s_d.cnt   = '0;
			s_d.phase = rpe_pkg::RPE_IDLE;
		end
		// counts advance on the tick only
		else if (tick)
		begin
			// wrap no later than the capped length
			if (s_q.phase == rpe_pkg::RPE_IDLE ||
				cnt_nx >= s_q.per)
			begin
				s_d.cnt   = '0;
				s_d.per   = eff_per;
				s_d.clamp = (s_q.req > max_per);
				s_d.phase = rpe_pkg::RPE_FIRST;
			end
			else
			begin
				s_d.cnt = cnt_nx;
				// halves split at a fixed midpoint
				if (cnt_nx < {1'b0, s_q.per[11:1]})
					s_d.phase = rpe_pkg::RPE_FIRST;
				else
					s_d.phase = rpe_pkg::RPE_SECOND;
			end
		end

		// drives follow the current count one cycle later
		// half-cycle gating
		s_d.drv.b = active && (s_q.phase == rpe_pkg::RPE_FIRST);
		s_d.drv.c = active && (s_q.phase == rpe_pkg::RPE_SECOND);
		s_d.drv.d = active && (s_q.phase == rpe_pkg::RPE_SECOND);
		s_d.drv.a = active && (s_q.phase == rpe_pkg::RPE_FIRST)
			&& ({1'b0, s_q.cnt} >= {5'h00, s_q.rise})
			&& ($signed({2'b00, s_q.cnt}) < $signed(fall_pt));
	end

	// state register; all outputs leave from here
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q       <= '0;
			s_q.freq  <= rpe_pkg::RST_FREQ_SET;
			s_q.rise  <= rpe_pkg::RST_RISE_DLY;
			s_q.maxhi <= rpe_pkg::RST_MAXPER_HI;
			s_q.fall  <= rpe_pkg::RST_FALL_OFS;
			s_q.maxlo <= rpe_pkg::RST_MAXPER_LO;
			s_q.req   <= rpe_pkg::RST_PER_REQ;
			s_q.per   <= rpe_pkg::PER_MIN;
			s_q.phase <= rpe_pkg::RPE_IDLE;
			s_q.busy  <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign avs_readdata        = s_q.rdata;
	assign avs_waitrequest     = s_q.busy;
	assign first_half_drive_a  = s_q.drv.a;
	assign first_half_drive_b  = s_q.drv.b;
	assign second_half_drive_c = s_q.drv.c;
	assign second_half_drive_d = s_q.drv.d;

	////////////////////////////////////////////////////////////////////////
	// checks

	// request is answered on the next cycle and released after
	sequence s_answer;
		req && avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	property p_bus_answer;
		@(posedge clk) disable iff (!rst_n)
		req && avs_waitrequest |-> s_answer;
	endproperty
	a_bus_answer: assert property (p_bus_answer)
		else $error("waitrequest did not drop one cycle after request");

	property p_enable;
		@(posedge clk) disable iff (!rst_n)
		(s_q.freq[5:0] != 6'h3F) |=> ##1 !(first_half_drive_a
			|| first_half_drive_b || second_half_drive_c
			|| second_half_drive_d);
	endproperty
	a_enable: assert property (p_enable)
		else $error("drive active outside resonant mode");

	property p_rise;
		@(posedge clk) disable iff (!rst_n)
		active && s_q.cnt < {4'h0, s_q.rise} |=> !first_half_drive_a;
	endproperty
	a_rise: assert property (p_rise)
		else $error("drive a rose before its delay");

	property p_rise_on;
		@(posedge clk) disable iff (!rst_n)
		active && s_q.phase == rpe_pkg::RPE_FIRST
			&& s_q.cnt == {4'h0, s_q.rise}
			&& $signed({2'b00, s_q.cnt}) < $signed(fall_pt)
			|=> first_half_drive_a;
	endproperty
	a_rise_on: assert property (p_rise_on)
		else $error("drive a missing at its rise count");

	property p_max_join;
		@(posedge clk) disable iff (!rst_n)
		active && tick && s_q.phase == rpe_pkg::RPE_IDLE
			&& s_q.req >= 12'h002
			|=> s_q.per <= {$past(s_q.maxhi), $past(s_q.maxlo[7:4])}
			|| s_q.per == 12'h002;
	endproperty
	a_max_join: assert property (p_max_join)
		else $error("cycle length above joined maximum");

	property p_count_bound;
		@(posedge clk) disable iff (!rst_n)
		s_q.phase != rpe_pkg::RPE_IDLE |-> s_q.cnt < s_q.per;
	endproperty
	a_count_bound: assert property (p_count_bound)
		else $error("cycle count passed the period");

	property p_fall;
		@(posedge clk) disable iff (!rst_n)
		active && $signed({2'b00, s_q.cnt}) >= $signed(fall_pt)
			|=> !first_half_drive_a;
	endproperty
	a_fall: assert property (p_fall)
		else $error("drive a high past its fall point");

	property p_halves;
		@(posedge clk) disable iff (!rst_n)
		(first_half_drive_a || first_half_drive_b) |->
			!second_half_drive_c && !second_half_drive_d
			&& $past(s_q.cnt) < {1'b0, $past(s_q.per[11:1])};
	endproperty
	a_halves: assert property (p_halves)
		else $error("first half drive outside first half");

	property p_duty;
		@(posedge clk) disable iff (!rst_n)
		active && tick && s_q.phase != rpe_pkg::RPE_IDLE |=>
			(first_half_drive_b != second_half_drive_c);
	endproperty
	a_duty: assert property (p_duty)
		else $error("fixed half split broken");

	property p_tick;
		@(posedge clk) disable iff (!rst_n)
		active && !tick |=> $stable(s_q.cnt) || s_q.cnt == 12'h000;
	endproperty
	a_tick: assert property (p_tick)
		else $error("count moved without a tick");

	property p_tick_step;
		@(posedge clk) disable iff (!rst_n)
		active && tick && s_q.phase != rpe_pkg::RPE_IDLE
			|=> $changed(s_q.cnt);
	endproperty
	a_tick_step: assert property (p_tick_step)
		else $error("count held across a tick");

endmodule // rpe_top

// ===== tb/rpe_switch_model.sv
// power-switch side model that times the four drives
`timescale 1ns/1ps

module rpe_switch_model
(
	// clock and reset
	input  wire logic                clk,
	input  wire logic                rst_n,
	// switch drives
	input  wire rpe_pkg::rpe_drive_t drv,
	// timing of the last whole cycle, a_ofs from the cycle in progress, overlap counted since reset
	output int                       per_len,
	output int                       b_len,
	output int                       a_len,
	output int                       a_ofs,
	output int                       overlap,
	// second half length and c against d
	output int                       c_len,
	output int                       cd_diff
);
	int   cnt;
	int   bh;
	int   ah;
	int   ch;
	logic b_q;

	////////////////////////////////////////////////////////////////////
	// cycles framed by drive b rising; switches only listen
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{cnt, bh, ah, per_len, b_len, a_len, a_ofs, overlap} <= '0;
			{ch, c_len, cd_diff} <= '0;
			b_q <= 1'b0;
		end
		else
		begin
			b_q <= drv.b;
			if ((drv.a | drv.b) & (drv.c | drv.d))
				overlap <= overlap + 1;
			// c and d share the second half
			if (drv.c !== drv.d)
				cd_diff <= cd_diff + 1;
			if (drv.b & !b_q)
			begin
				per_len <= cnt;
				b_len   <= bh;
				a_len   <= ah;
				c_len   <= ch;
				cnt     <= 1;
				bh      <= 1;
				ah      <= int'(drv.a);
				ch      <= int'(drv.c);
			end
			else
			begin
				cnt <= cnt + 1;
				bh  <= bh + int'(drv.b);
				ah  <= ah + int'(drv.a);
				ch  <= ch + int'(drv.c);
				if (drv.a & (ah == 0))
					a_ofs <= cnt;
			end
		end
	end
endmodule // rpe_switch_model

// ===== tb/tb.sv
// self-checking bench for the resonant edge-timing block
`timescale 1ns/1ps

module tb;
	logic                clk;
	logic                rst_n;
	logic [9:0]          avs_address;
	logic                avs_read;
	logic                avs_write;
	logic [31:0]         avs_writedata;
	logic [3:0]          avs_byteenable;
	logic [31:0]         avs_readdata;
	logic                avs_waitrequest;
	logic                da;
	logic                db;
	logic                dc;
	logic                dd;
	rpe_pkg::rpe_drive_t drv;
	int                  per_len;
	int                  b_len;
	int                  a_len;
	int                  a_ofs;
	int                  overlap;
	int                  c_len;
	int                  cd_diff;
	int                  ep;
	int                  n_errors = 0;
	int                  cmp_count = 0;
	logic [31:0]         seed = 32'hB3F055A9;
	logic [31:0]         rd;
	logic [31:0]         vals [5];
	int                  rq;
	int                  rs;
	int                  fl;

	assign drv = {da, db, dc, dd};

	rpe_top uut
	(
		.clk                 (clk),
		.rst_n               (rst_n),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_byteenable      (avs_byteenable),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.first_half_drive_a  (da),
		.first_half_drive_b  (db),
		.second_half_drive_c (dc),
		.second_half_drive_d (dd)
	);

	rpe_switch_model sw
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.drv     (drv),
		.per_len (per_len),
		.b_len   (b_len),
		.a_len   (a_len),
		.a_ofs   (a_ofs),
		.overlap (overlap),
		.c_len   (c_len),
		.cd_diff (cd_diff)
	);

	////////////////////////////////////////////////////////////////////
	// 200 MHz clock
	always #2.5 clk = ~clk;

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// clamp to the limit, floor of two ticks
	function automatic int exp_per(int r, int mx);
		return r > mx ? mx : (r < 2 ? 2 : r);
	endfunction

	// positive offsets are cut at the midpoint
	function automatic int exp_alen(int r, int f, int hf);
		int e;
		e = f < 128 ? hf : hf - (256 - f);
		return e > r ? e - r : 0;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] ex,
		input string m);
		cmp_count++;
		if (got !== ex)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %0h want %0h", $time, m, got, ex);
		end
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] ix,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		avs_address   <= {ix, 2'b00};
		avs_write     <= w;
		avs_read      <= !w;
		avs_writedata <= wd;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		// one wait cycle, so low is seen at the second edge
		chk(n, 2, "bus wait");
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wt(int n);
		repeat (n) @(posedge clk);
	endtask

	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	// watchdog sized well past the whole sequence
	initial
	begin
		wt(20000);
		n_errors++;
		tally_and_finish;
	end

	// main sequence
	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		avs_byteenable = 4'hF;
		wt(3);
		rst_n <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			bus(0, 8'(8'h40 + i), '0);
			chk(rd, '0, "reset value");
		end
		chk(drv, '0, "drives idle");
		for (int i = 0; i < 5; i++)
		begin
			vals[i] = rnd() & 32'hFF;
			bus(1, 8'(8'h40 + i), vals[i]);
			bus(0, 8'(8'h40 + i), '0);
			chk(rd, vals[i], "readback");
		end
		bus(1, 8'h50, 32'hFF);
		bus(0, 8'h50, '0);
		chk(rd, '0, "unmapped");
		avs_byteenable <= 4'hE;
		bus(1, 8'h41, ~vals[1]);
		avs_byteenable <= 4'hF;
		bus(0, 8'h41, '0);
		chk(rd, vals[1], "lane0 off");
		$display("test registers done");
		// disabled with code one short of all ones, then enabled
		bus(1, 8'h42, 32'h01);
		bus(1, 8'h44, 32'h00);
		bus(1, 8'h60, 32'h10);
		bus(1, 8'h40, 32'h3E);
		wt(40);
		chk(drv, '0, "not resonant");
		bus(1, 8'h40, 32'hFF);
		wt(60);
		bus(0, 8'h61, '0);
		chk(rd[0], 1'b1, "active");
		chk(per_len, 16, "period");
		$display("test enable done");
		// limit from high byte and nibble, clamp and floor
		for (int k = 0; k < 4; k++)
		begin
			rq = k == 3 ? int'(rnd() % 20) : (k == 1 ? 1 : 32);
			bus(1, 8'h42, k == 0 ? 32'h00 : 32'h01);
			bus(1, 8'h44, k == 0 ? 32'h8F : 32'h00);
			bus(1, 8'h60, rq);
			wt(60);
			bus(0, 8'h61, '0);
			chk(rd[2], rq > (k == 0 ? 8 : 16), "clamp");
			chk(per_len, exp_per(rq, k == 0 ? 8 : 16), "per");
			chk(b_len, exp_per(rq, k == 0 ? 8 : 16) / 2, "duty");
			ep = exp_per(rq, k == 0 ? 8 : 16);
			chk(c_len, ep - ep / 2, "second half");
		end
		$display("test limits done");
		// drive a edges about start and midpoint
		bus(1, 8'h60, 32'h10);
		for (int k = 0; k < 6; k++)
		begin
			rs = 1 + int'(rnd() % 4);
			fl = k[0] ? 253 + int'(rnd() % 3) : int'(rnd() % 128);
			bus(1, 8'h41, rs);
			bus(1, 8'h43, fl);
			wt(60);
			chk(a_ofs, rs, "a rise");
			chk(a_len, exp_alen(rs, fl, 8), "a fall");
		end
		chk(overlap, 0, "halves");
		chk(cd_diff, 0, "c equals d");
		// upper request bits kept when lane 1 is off
		avs_byteenable <= 4'h1;
		bus(1, 8'h60, 32'hF0A);
		avs_byteenable <= 4'hF;
		bus(0, 8'h60, '0);
		chk(rd, 32'h00A, "lane1 off");
		$display("test drive a done");
		tally_and_finish;
	end
endmodule // tb
